/* upmc_host.sv */
// Host controller driving a byte-wide prom array over its pins
`timescale 1ns/1ps
// Operation
// - Program pulse only on selected chip select
// - Shared lines, per-device chip selects
// - Verify with both selects low, read back
// - Identification voltage with selects low
// - Byte select low then high
// - Other address lines low in identification
// - Data driven only with chip select low, output enable high
// - Decoded chip select, common output enable
// - Program with chip select low, high voltage
module upmc_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Command port
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [1:0] cmd_dev,
    input wire logic [upmc_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [upmc_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [upmc_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_mismatch,
    output logic rsp_parity_err,
    // Device pins
    output logic [upmc_pkg::ADDR_W-1:0] addr_out,
    output logic [upmc_pkg::NDEV-1:0] chip_sel_n,
    output logic out_en_n,
    output logic prog_volt_en,
    output logic ident_volt_en,
    output logic [upmc_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [upmc_pkg::DATA_W-1:0] data_lines_in
);
    upmc_pkg::upmc_state_e state_q;
    logic [1:0] op_q;
    logic [1:0] dev_q;
    logic [upmc_pkg::DATA_W-1:0] wdata_q;
    logic tmr_load;
    logic [upmc_pkg::CNT_W-1:0] tmr_value;
    logic tmr_done;
    logic [upmc_pkg::NDEV-1:0] dev_hit;

    upmc_timer u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(clk_en),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    always_comb begin
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_q)
            upmc_pkg::UPMC_IDLE: begin
                if (cmd_valid) begin
                    tmr_load = 1'b1;
                    tmr_value = upmc_pkg::CNT_W'(upmc_pkg::ACC_CYC);
                end
            end
            upmc_pkg::UPMC_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = (op_q == upmc_pkg::CMD_PROGRAM) ? upmc_pkg::CNT_W'(upmc_pkg::PULSE_CYC)
                                                                 : upmc_pkg::CNT_W'(upmc_pkg::OE_CYC);
                end
            end
            upmc_pkg::UPMC_PULSE: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = upmc_pkg::CNT_W'(upmc_pkg::ACC_CYC);
                end
            end
            upmc_pkg::UPMC_ACCESS, upmc_pkg::UPMC_VERIFY: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = upmc_pkg::CNT_W'(upmc_pkg::DF_CYC);
                end
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= upmc_pkg::UPMC_IDLE;
        end else if (clk_en) begin
            case (state_q)
                upmc_pkg::UPMC_IDLE: if (cmd_valid) state_q <= upmc_pkg::UPMC_SETUP;
                upmc_pkg::UPMC_SETUP: begin
                    if (tmr_done) begin
                        state_q <= (op_q == upmc_pkg::CMD_PROGRAM) ? upmc_pkg::UPMC_PULSE : upmc_pkg::UPMC_ACCESS;
                    end
                end
                upmc_pkg::UPMC_PULSE: if (tmr_done) state_q <= upmc_pkg::UPMC_VERIFY;
                upmc_pkg::UPMC_ACCESS, upmc_pkg::UPMC_VERIFY: if (tmr_done) state_q <= upmc_pkg::UPMC_FLOAT;
                upmc_pkg::UPMC_FLOAT: if (tmr_done) state_q <= upmc_pkg::UPMC_IDLE;
                default: state_q <= upmc_pkg::UPMC_IDLE;
            endcase
        end
    end

    // Command capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= upmc_pkg::CMD_READ;
            dev_q <= 2'h0;
            wdata_q <= 8'hFF;
        end else if (clk_en && state_q == upmc_pkg::UPMC_IDLE && cmd_valid) begin
            op_q <= cmd_op;
            dev_q <= cmd_dev;
            wdata_q <= cmd_wdata;
        end
    end

    // Address: identification forces all lines low except byte select
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_out <= '0;
        end else if (clk_en && state_q == upmc_pkg::UPMC_IDLE && cmd_valid) begin
            if (cmd_op == upmc_pkg::CMD_IDENT) begin
                addr_out <= cmd_addr[0] ? upmc_pkg::ID_ADDR_DEV : upmc_pkg::ID_ADDR_MFR;
            end else begin
                addr_out <= cmd_addr;
            end
        end
    end

    // Per-device selects share one decoder; unselected devices stay high
    for (genvar i = 0; i < upmc_pkg::NDEV; i++) begin : g_sel
        assign dev_hit[i] = (dev_q == 2'(i));
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                chip_sel_n[i] <= 1'b1;
            end else if (clk_en) begin
                // Held low across phase changes so a read strobe never meets a released select
                if (dev_hit[i] && (state_q == upmc_pkg::UPMC_SETUP || state_q == upmc_pkg::UPMC_PULSE)) begin
                    chip_sel_n[i] <= 1'b0;
                end else if (dev_hit[i] && (state_q == upmc_pkg::UPMC_ACCESS || state_q == upmc_pkg::UPMC_VERIFY)
                             && !tmr_done) begin
                    chip_sel_n[i] <= 1'b0;
                end else if (cmd_dev == 2'(i) && state_q == upmc_pkg::UPMC_IDLE && cmd_valid) begin
                    // New device index, the captured one is still the old command's
                    chip_sel_n[i] <= 1'b0;
                end else begin
                    chip_sel_n[i] <= 1'b1;
                end
            end
        end
    end

    // Output enable and high voltages
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_en_n <= 1'b1;
            prog_volt_en <= 1'b0;
            ident_volt_en <= 1'b0;
        end else if (clk_en) begin
            // Common read strobe low only while the bus is to be read
            out_en_n <= !((state_q == upmc_pkg::UPMC_ACCESS || state_q == upmc_pkg::UPMC_VERIFY) && !tmr_done
                          || (state_q == upmc_pkg::UPMC_SETUP && tmr_done && op_q != upmc_pkg::CMD_PROGRAM)
                          || (state_q == upmc_pkg::UPMC_PULSE && tmr_done));
            prog_volt_en <= (state_q == upmc_pkg::UPMC_SETUP && op_q == upmc_pkg::CMD_PROGRAM && tmr_done)
                            || (state_q == upmc_pkg::UPMC_PULSE && !tmr_done);
            if (state_q == upmc_pkg::UPMC_IDLE && cmd_valid) begin
                ident_volt_en <= (cmd_op == upmc_pkg::CMD_IDENT);
            end else if (state_q == upmc_pkg::UPMC_FLOAT && tmr_done) begin
                ident_volt_en <= 1'b0;
            end
        end
    end

    // Data drive only during the program pulse, so no fight with the device
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_lines_out <= 8'hFF;
            data_lines_oe_n <= 1'b1;
        end else if (clk_en) begin
            data_lines_out <= wdata_q;
            data_lines_oe_n <= !((state_q == upmc_pkg::UPMC_SETUP && op_q == upmc_pkg::CMD_PROGRAM && tmr_done)
                                 || (state_q == upmc_pkg::UPMC_PULSE && !tmr_done));
        end
    end

    // Response sampled at end of access window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_mismatch <= 1'b0;
            rsp_parity_err <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            if ((state_q == upmc_pkg::UPMC_ACCESS || state_q == upmc_pkg::UPMC_VERIFY) && tmr_done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_lines_in;
                // Verify only flags zeros that failed to stick
                rsp_mismatch <= (state_q == upmc_pkg::UPMC_VERIFY) && ((data_lines_in & ~wdata_q) != '0);
                rsp_parity_err <= (op_q == upmc_pkg::CMD_IDENT) && !(^data_lines_in);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
        end else if (clk_en) begin
            cmd_ready <= (state_q == upmc_pkg::UPMC_IDLE && !cmd_valid)
                         || (state_q == upmc_pkg::UPMC_FLOAT && tmr_done);
        end
    end
endmodule

/* upmc_pkg.sv */
// Constants shared by the prom host controller
package upmc_pkg;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Access delays in ns, as for the slowest speed grade
    localparam int unsigned ADDRESS_ACCESS_DELAY_NS = 250;
    localparam int unsigned OUTPUT_ENABLE_DELAY_NS = 75;
    localparam int unsigned FLOAT_DELAY_NS = 30;
    // Program pulse in us
    localparam int unsigned PROG_PULSE_US = 100;
    localparam int unsigned ACC_CYC = (ADDRESS_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned OE_CYC = (OUTPUT_ENABLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DF_CYC = (FLOAT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned PULSE_CYC = (PROG_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NDEV = 4;
    localparam int unsigned CNT_W = 16;
    localparam logic [ADDR_W-1:0] ID_ADDR_MFR = 16'h0000;
    localparam logic [ADDR_W-1:0] ID_ADDR_DEV = 16'h0001;
    localparam int unsigned PARITY_BIT = 7;
    // Command codes
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROGRAM = 2'h1;
    localparam logic [1:0] CMD_IDENT = 2'h2;
    typedef enum logic [5:0] {
        UPMC_IDLE = 6'h01,
        UPMC_SETUP = 6'h02,
        UPMC_ACCESS = 6'h04,
        UPMC_PULSE = 6'h08,
        UPMC_VERIFY = 6'h10,
        UPMC_FLOAT = 6'h20
    } upmc_state_e;
endpackage

/* upmc_timer.sv */
// Down counter for pin timing
`timescale 1ns/1ps
module upmc_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [upmc_pkg::CNT_W-1:0] value,
    output logic done
);
    logic [upmc_pkg::CNT_W-1:0] cnt_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= value;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
    // Zero count alone; the load request is built from it, so no path back
    assign done = (cnt_q == '0);
endmodule

/* upmc_host_asserts.sv */
// Pin-level checks on the prom host controller
`timescale 1ns/1ps
module upmc_host_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pins and response
    input wire logic [15:0] addr_out,
    input wire logic [3:0] chip_sel_n,
    input wire logic out_en_n,
    input wire logic prog_volt_en,
    input wire logic ident_volt_en,
    input wire logic data_lines_oe_n,
    input wire logic rsp_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_one_sel;
        $countones(~chip_sel_n) == 1;
    endsequence
    sequence s_read_run;
        !out_en_n [*4];
    endsequence
    a_prog_one_sel: assert property (prog_volt_en |-> s_one_sel) else $error("vpp select");
    a_prog_pins: assert property (prog_volt_en |-> out_en_n && !data_lines_oe_n && !ident_volt_en)
        else $error("program pins");
    a_no_contend: assert property (!data_lines_oe_n |-> out_en_n) else $error("bus contention");
    a_ident_addr: assert property (ident_volt_en |-> addr_out[15:1] == 15'h0000) else $error("ident addr");
    a_ident_sel: assert property (ident_volt_en && !out_en_n |-> s_one_sel) else $error("ident select");
    a_oe_selected: assert property ($fell(out_en_n) |-> s_one_sel) else $error("oe select");
    a_oe_run: assert property ($fell(out_en_n) |-> s_read_run) else $error("oe too short");
    a_addr_stable: assert property (!out_en_n && !$past(out_en_n) |-> $stable(addr_out))
        else $error("addr moved");
    a_rsp_after_read: assert property (rsp_valid |-> !$past(out_en_n) || !$past(out_en_n, 2))
        else $error("rsp without read");
endmodule

/* upmc_prom_model.sv */
// Behavioural prom device on one chip select
`timescale 1ns/1ps
module upmc_prom_model #(
    // Identifier values are arbitrary
    parameter logic [7:0] MFR_ID = 8'h4C,
    parameter logic [7:0] DEV_ID = 8'h2A
) (
    // Clock
    input wire logic mclk,
    // Pins
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic vpp,
    input wire logic vid,
    input wire logic [15:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic drive
);
    logic [7:0] mem [0:65535];
    logic [7:0] word;
    logic [1:0] cnt;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        cnt = 2'h0;
    end
    assign drive = !cs_n && !oe_n && !vpp;
    assign word = vid ? (addr[0] ? DEV_ID : MFR_ID) : mem[addr];
    // Not yet settled shows the inverse, so an early sample fails
    assign dout = (cnt == 2'h3) ? word : ~word;
    always @(posedge mclk) begin
        cnt <= drive ? ((cnt == 2'h3) ? cnt : cnt + 2'h1) : 2'h0;
        if (!cs_n && vpp) begin
            mem[addr] <= mem[addr] & din;
        end
    end
endmodule

/* uv_prom_mode_control_bench.sv */
// Self-checking bench for the prom host controller
`timescale 1ns/1ps
module uv_prom_mode_control_bench;
    localparam logic [7:0] MFR0 = 8'h4C;
    localparam logic [7:0] DEV0 = 8'h2A;
    localparam logic [7:0] MFR1 = 8'h4D;
    logic mclk, rst_n, clk_en, cmd_valid, cmd_ready, rsp_valid, rsp_mismatch, rsp_parity_err;
    logic out_en_n, prog_volt_en, ident_volt_en, data_lines_oe_n;
    logic [1:0] cmd_op, cmd_dev, drv;
    logic [15:0] cmd_addr, addr_out;
    logic [7:0] cmd_wdata, rsp_rdata, data_lines_out, data_lines_in, q0, q1;
    logic [7:0] bus_last = 8'h00;
    logic [3:0] chip_sel_n;
    int errors = 0;
    int samples_checked = 0;
    upmc_host u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_mismatch(rsp_mismatch),
        .rsp_parity_err(rsp_parity_err), .addr_out(addr_out), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .prog_volt_en(prog_volt_en), .ident_volt_en(ident_volt_en), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in));
    upmc_prom_model #(.MFR_ID(MFR0), .DEV_ID(DEV0)) u_dev0 (.mclk(mclk), .cs_n(chip_sel_n[0]), .oe_n(out_en_n),
        .vpp(prog_volt_en), .vid(ident_volt_en), .addr(addr_out), .din(data_lines_out), .dout(q0), .drive(drv[0]));
    upmc_prom_model #(.MFR_ID(MFR1), .DEV_ID(DEV0)) u_dev1 (.mclk(mclk), .cs_n(chip_sel_n[1]), .oe_n(out_en_n),
        .vpp(prog_volt_en), .vid(ident_volt_en), .addr(addr_out), .din(data_lines_out), .dout(q1), .drive(drv[1]));
    // Undriven bus shows the inverse of its last level
    assign data_lines_in = !data_lines_oe_n ? data_lines_out : drv[0] ? q0 : drv[1] ? q1 : ~bus_last;
    always @(posedge mclk) bus_last <= data_lines_in;
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic finish_test;
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic run_cmd(input logic [1:0] op, input logic [1:0] dev, input logic [15:0] addr, input logic [7:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n++;
        end
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_dev <= dev;
        cmd_addr <= addr;
        cmd_wdata <= wd;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (rsp_valid !== 1'b1 && n < 13000);
        check("rsp_valid", 8'h01, {7'h00, rsp_valid});
    endtask
    // A request offered while the enable is low must not be taken
    task automatic t_freeze;
        @(posedge mclk);
        clk_en <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_op <= upmc_pkg::CMD_READ;
        cmd_dev <= 2'h1;
        repeat (3) @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        check("frozen selects", 8'h0F, {4'h0, chip_sel_n});
        check("frozen ready", 8'h01, {7'h00, cmd_ready});
        @(posedge mclk);
        clk_en <= 1'b1;
    endtask
    task automatic t_erased_read;
        run_cmd(upmc_pkg::CMD_READ, 2'h0, 16'hFFFF, 8'h00);
        check("erased byte", 8'hFF, rsp_rdata);
    endtask
    task automatic t_program;
        run_cmd(upmc_pkg::CMD_PROGRAM, 2'h0, 16'h0234, 8'hA5);
        check("verify data", 8'hA5, rsp_rdata);
        check("verify mismatch", 8'h00, {7'h00, rsp_mismatch});
        run_cmd(upmc_pkg::CMD_READ, 2'h1, 16'h0234, 8'h00);
        check("inhibited byte", 8'hFF, rsp_rdata);
        run_cmd(upmc_pkg::CMD_READ, 2'h0, 16'h0034, 8'h00);
        check("other byte", 8'hFF, rsp_rdata);
        run_cmd(upmc_pkg::CMD_PROGRAM, 2'h0, 16'h0234, 8'hFF);
        check("zeros kept", 8'hA5, rsp_rdata);
    endtask
    task automatic t_ident;
        run_cmd(upmc_pkg::CMD_IDENT, 2'h0, 16'h0000, 8'h00);
        check("maker code", MFR0, rsp_rdata);
        check("maker parity", 8'h00, {7'h00, rsp_parity_err});
        run_cmd(upmc_pkg::CMD_IDENT, 2'h0, 16'hFF01, 8'h00);
        check("device code", DEV0, rsp_rdata);
        run_cmd(upmc_pkg::CMD_IDENT, 2'h1, 16'h0000, 8'h00);
        check("even parity flag", 8'h01, {7'h00, rsp_parity_err});
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_dev = 2'h0;
        cmd_addr = 16'h0000;
        cmd_wdata = 8'h00;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_freeze;
        t_erased_read;
        t_program;
        t_ident;
        finish_test;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        finish_test;
    end
endmodule
bind upmc_host upmc_host_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .addr_out(addr_out), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .prog_volt_en(prog_volt_en), .ident_volt_en(ident_volt_en),
    .data_lines_oe_n(data_lines_oe_n), .rsp_valid(rsp_valid));
